/* verilog/kco_coef_override_ctrl.sv */
// Purpose: control and status bank for the per-lane coefficient override path
// Assumes: status and training word inputs come from logic on clk_in
// Notes:   strobes self clear after one cycle
//
// Notes on behaviour
// (R1) A 1 written to bit 10 loads the lane-2 transmit coefficients from the lane-2 field at bits 23:16.
// (R2) The lane-2 and lane-3 apply strobes act only while the local override enable is set.
// (R3) A 1 written to bit 11 loads the lane-3 transmit coefficients from the lane-3 field at bits 23:16.
// (R4) Lane-1 training status reads at bits 13:8 of the status register with the lane-0 layout.
// (R5) Lane-2 status reads at bits 21:16 and lane-3 status at bits 29:24, read-only.
// (R6) Software judges a frame lock error unrecoverable when the lane taps still equal the initial values.
// (R7) The lane-0 update register reflects the current training word sent by the local device on lane 0.
// (R8) The lane-0 update bits are writable only while the partner override enable is set.
// (R9) The update word carries post, main and pre requests in bits 5:4, 3:2 and 1:0 alike.
// (R10) Each request reads 00 as hold and 10 as decrement, and 11 is never taken as valid.
// (R11) Software sets the partner override enable before pulsing the new-word strobe at bit 4.
// (R12) The local override enable hands the local transmit coefficients to software.
// (R13) The partner override enable lets software choose the requests sent to the partner.
// (R14) A request of 01 means increment.
`timescale 1ns/1ps
module kco_coef_override_ctrl (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // AXI4-Lite write
  input  wire logic [kco_pkg::KCO_AW-1:0] s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic      [1:0]                s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [kco_pkg::KCO_AW-1:0] s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic      [31:0]               s_axi_rdata_out,
  output logic      [1:0]                s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  // training status per lane
  input  wire logic [5:0]                lane0_status_in,
  input  wire logic [5:0]                lane1_status_in,
  input  wire logic [5:0]                lane2_status_in,
  input  wire logic [5:0]                lane3_status_in,
  // training-generated update word for lane 0
  input  wire logic [5:0]                lt_coef_word_in,
  // local coefficient apply
  output logic                           lane2_coef_load_out,
  output logic      [7:0]                lane2_coef_out,
  output logic                           lane3_coef_load_out,
  output logic      [7:0]                lane3_coef_out,
  output logic                           local_rx_override_out,
  // partner update word
  output logic                           partner_coef_override_en_out,
  output logic      [5:0]                tx_coef_word_out,
  output logic                           tx_word_new_out,
  output logic      [2:0]                req_hold_out,
  output logic      [2:0]                req_inc_out,
  output logic      [2:0]                req_dec_out,
  output logic      [2:0]                req_rsvd_out
);
  import kco_pkg::*;

  typedef struct packed {
    logic       part_ovr;
    logic       loc_ovr;
    logic [7:0] coef2;
    logic [7:0] coef3;
    logic [5:0] sw_word;
    logic [5:0] word;
    logic       load2;
    logic       load3;
    logic       new_word;
  } kco_regs_t;

  kco_regs_t st_r;
  kco_regs_t st_nxt;

  logic                  wr_fire;
  logic [KCO_AW-1:0]     wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_hit;
  logic                  rd_fire;
  logic [KCO_AW-1:0]     rd_addr;
  logic [31:0]           rd_data;
  logic                  rd_hit;

  logic [31:0]           ctrl_img;
  logic [31:0]           strb_img;
  logic [31:0]           stat_img;
  logic [31:0]           strobe_w;
  logic [31:0]           ctrl_w;
  logic                  sw_rsvd;
  logic                  word_wr;
  logic                  strobe_wr;
  // merge results
  logic [31:0]           coef2_w;
  logic [31:0]           coef3_w;
  logic [31:0]           word_w;
  logic [3:0]            fld_dec;

  // ==========================================================================
  // bus front end
  kco_axil_slave i_kco_axil_slave (
    .clk_in            (clk_in),
    .sys_rst_in        (sys_rst_in),
    .s_axi_awaddr_in   (s_axi_awaddr_in),
    .s_axi_awvalid_in  (s_axi_awvalid_in),
    .s_axi_awready_out (s_axi_awready_out),
    .s_axi_wdata_in    (s_axi_wdata_in),
    .s_axi_wstrb_in    (s_axi_wstrb_in),
    .s_axi_wvalid_in   (s_axi_wvalid_in),
    .s_axi_wready_out  (s_axi_wready_out),
    .s_axi_bresp_out   (s_axi_bresp_out),
    .s_axi_bvalid_out  (s_axi_bvalid_out),
    .s_axi_bready_in   (s_axi_bready_in),
    .s_axi_araddr_in   (s_axi_araddr_in),
    .s_axi_arvalid_in  (s_axi_arvalid_in),
    .s_axi_arready_out (s_axi_arready_out),
    .s_axi_rdata_out   (s_axi_rdata_out),
    .s_axi_rresp_out   (s_axi_rresp_out),
    .s_axi_rvalid_out  (s_axi_rvalid_out),
    .s_axi_rready_in   (s_axi_rready_in),
    .wr_fire_out       (wr_fire),
    .wr_addr_out       (wr_addr),
    .wr_data_out       (wr_data),
    .wr_strb_out       (wr_strb),
    .wr_hit_in         (wr_hit),
    .rd_fire_out       (rd_fire),
    .rd_addr_out       (rd_addr),
    .rd_data_in        (rd_data),
    .rd_hit_in         (rd_hit)
  );

  // ==========================================================================
  // request decode of the outgoing word
  kco_req_decode i_kco_req_decode (
    .word_in  (st_r.word),
    .hold_out (req_hold_out),
    .inc_out  (req_inc_out),   // [R14]
    .dec_out  (req_dec_out),   // [R9]
    .rsvd_out (req_rsvd_out)   // [R10]
  );

  // ==========================================================================
  // address decode and register images
  // index decode shared by the read and write sides
  function automatic logic kco_map_hit(input logic [KCO_AW-1:0] addr);
    return kco_addr_hit(addr, KCO_IDX_CTRL)   | kco_addr_hit(addr, KCO_IDX_STROBE) |
           kco_addr_hit(addr, KCO_IDX_STATUS) | kco_addr_hit(addr, KCO_IDX_WORD)   |
           kco_addr_hit(addr, KCO_IDX_COEF2)  | kco_addr_hit(addr, KCO_IDX_COEF3);
  endfunction : kco_map_hit

  assign wr_hit = kco_map_hit(wr_addr);
  assign rd_hit = kco_map_hit(rd_addr);
  assign word_wr   = wr_fire & kco_addr_hit(wr_addr, KCO_IDX_WORD);
  assign strobe_wr = wr_fire & kco_addr_hit(wr_addr, KCO_IDX_STROBE);

  always_comb begin
    ctrl_img = 32'h0;
    ctrl_img[KCO_BIT_PART_OVR] = st_r.part_ovr;
    ctrl_img[KCO_BIT_LOC_OVR]  = st_r.loc_ovr;
    strb_img = 32'h0;
    strb_img[KCO_BIT_NEW_WORD] = st_r.new_word;
    strb_img[KCO_BIT_APPLY2]   = st_r.load2;
    strb_img[KCO_BIT_APPLY3]   = st_r.load3;
    // reserved bits between the fields read zero
    stat_img = 32'h0;
    stat_img[KCO_STAT0_LSB +: 6] = lane0_status_in;
    stat_img[KCO_STAT1_LSB +: 6] = lane1_status_in;   // [R4]
    stat_img[KCO_STAT2_LSB +: 6] = lane2_status_in;   // [R5]
    stat_img[KCO_STAT3_LSB +: 6] = lane3_status_in;   // [R5]
    ctrl_w   = kco_merge(ctrl_img, wr_data, wr_strb);
    strobe_w = kco_merge(32'h0, wr_data, wr_strb);
    coef2_w  = kco_merge({8'h0, st_r.coef2, 16'h0}, wr_data, wr_strb);
    coef3_w  = kco_merge({8'h0, st_r.coef3, 16'h0}, wr_data, wr_strb);
    word_w   = kco_merge({26'h0, st_r.sw_word}, wr_data, wr_strb);
    // a word holding 11 in any field is never sent as a request
    sw_rsvd = 1'b0;
    fld_dec = 4'h0;
    for (int i = 0; i < 3; i++) begin
      fld_dec = kco_req_decode(st_r.sw_word[2*i +: 2]);
      sw_rsvd = sw_rsvd | fld_dec[3];   // [R10]
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rd_data = 32'h0;
    if (kco_addr_hit(rd_addr, KCO_IDX_CTRL)) begin
      rd_data = ctrl_img;
    end else if (kco_addr_hit(rd_addr, KCO_IDX_STROBE)) begin
      rd_data = strb_img;
    end else if (kco_addr_hit(rd_addr, KCO_IDX_STATUS)) begin
      rd_data = stat_img;
    end else if (kco_addr_hit(rd_addr, KCO_IDX_WORD)) begin
      rd_data[5:0] = st_r.word;   // [R7]
    end else if (kco_addr_hit(rd_addr, KCO_IDX_COEF2)) begin
      rd_data[KCO_COEF_LSB +: 8] = st_r.coef2;
    end else if (kco_addr_hit(rd_addr, KCO_IDX_COEF3)) begin
      rd_data[KCO_COEF_LSB +: 8] = st_r.coef3;
    end
  end

  // ==========================================================================
  // register update
  always_comb begin
    st_nxt          = st_r;
    st_nxt.load2    = 1'b0;
    st_nxt.load3    = 1'b0;
    st_nxt.new_word = 1'b0;
    if (wr_fire && kco_addr_hit(wr_addr, KCO_IDX_CTRL)) begin
      st_nxt.part_ovr = ctrl_w[KCO_BIT_PART_OVR];   // [R13]
      st_nxt.loc_ovr  = ctrl_w[KCO_BIT_LOC_OVR];    // [R12]
    end
    if (strobe_wr) begin
      st_nxt.load2    = strobe_w[KCO_BIT_APPLY2] & st_r.loc_ovr;   // [R1] [R2]
      st_nxt.load3    = strobe_w[KCO_BIT_APPLY3] & st_r.loc_ovr;   // [R3] [R2]
      st_nxt.new_word = strobe_w[KCO_BIT_NEW_WORD] & st_r.part_ovr & ~sw_rsvd;   // [R11] [R10]
    end
    if (wr_fire && kco_addr_hit(wr_addr, KCO_IDX_COEF2)) begin
      st_nxt.coef2 = coef2_w[KCO_COEF_LSB +: 8];
    end
    if (wr_fire && kco_addr_hit(wr_addr, KCO_IDX_COEF3)) begin
      st_nxt.coef3 = coef3_w[KCO_COEF_LSB +: 8];
    end
    // outside override the software copy follows training so that enabling starts from live value
    if (!st_r.part_ovr) begin
      st_nxt.sw_word = lt_coef_word_in;
    end else if (word_wr) begin
      st_nxt.sw_word = word_w[5:0];   // [R8]
    end
    st_nxt.word = st_r.part_ovr ? st_r.sw_word : lt_coef_word_in;   // [R7] [R13]
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '{part_ovr: KCO_OVR_RST, loc_ovr: KCO_OVR_RST,
                coef2: KCO_COEF_RST, coef3: KCO_COEF_RST,
                sw_word: KCO_WORD_RST, word: KCO_WORD_RST,
                load2: 1'b0, load3: 1'b0, new_word: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign lane2_coef_load_out          = st_r.load2;
  assign lane2_coef_out               = st_r.coef2;
  assign lane3_coef_load_out          = st_r.load3;
  assign lane3_coef_out               = st_r.coef3;
  assign local_rx_override_out        = st_r.loc_ovr;
  assign partner_coef_override_en_out = st_r.part_ovr;
  assign tx_coef_word_out             = st_r.word;
  assign tx_word_new_out              = st_r.new_word;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_load2_cause;
    strobe_wr && wr_strb[1] && wr_data[KCO_BIT_APPLY2] && st_r.loc_ovr
      |=> lane2_coef_load_out;
  endproperty
  a_load2_cause: assert property (p_load2_cause) else $error("lane2 apply lost");   // [R1]

  property p_coef2_field;
    wr_fire && kco_addr_hit(wr_addr, KCO_IDX_COEF2) && wr_strb[2]
      |=> lane2_coef_out == $past(wr_data[KCO_COEF_LSB +: 8]);
  endproperty
  a_coef2_field: assert property (p_coef2_field) else $error("lane2 field not stored");   // [R1]

  property p_load_gate;
    (lane2_coef_load_out || lane3_coef_load_out)
      |-> $past(st_r.loc_ovr) && $past(strobe_wr);
  endproperty
  a_load_gate: assert property (p_load_gate) else $error("apply without local override");   // [R2]

  property p_load3_pulse;
    strobe_wr && wr_strb[1] && wr_data[KCO_BIT_APPLY3] && st_r.loc_ovr
      |=> lane3_coef_load_out ##1 !lane3_coef_load_out;
  endproperty
  a_load3_pulse: assert property (p_load3_pulse) else $error("lane3 apply not one pulse");   // [R3]

  property p_status;
    rd_fire && kco_addr_hit(rd_addr, KCO_IDX_STATUS)
      |=> s_axi_rdata_out[13:8] == $past(lane1_status_in) && s_axi_rdata_out[21:16] == $past(lane2_status_in)
          && s_axi_rdata_out[29:24] == $past(lane3_status_in) && s_axi_rdata_out[7:6] == 2'h0;
  endproperty
  a_status: assert property (p_status) else $error("status fields misplaced");   // [R4] [R5]

  property p_word_track;
    !st_r.part_ovr |=> tx_coef_word_out == $past(lt_coef_word_in);
  endproperty
  a_word_track: assert property (p_word_track) else $error("word does not follow training");   // [R7]

  property p_word_hold;
    st_r.part_ovr && !word_wr ##1 st_r.part_ovr |=> $stable(tx_coef_word_out);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("override word changed unwritten");   // [R8]

  property p_word_write;
    word_wr && st_r.part_ovr && wr_strb[0] |=> ##1 tx_coef_word_out == $past(wr_data[5:0], 2);
  endproperty
  a_word_write: assert property (p_word_write) else $error("override word write lost");   // [R8]

  property p_new_word;
    tx_word_new_out
      |-> $past(st_r.part_ovr) && !$past(sw_rsvd);
  endproperty
  a_new_word: assert property (p_new_word) else $error("new word sent without override");   // [R13]

  property p_dec_main;
    tx_coef_word_out[3:2] == KCO_REQ_DEC
      |-> req_dec_out[1] && !req_inc_out[1];
  endproperty
  a_dec_main: assert property (p_dec_main) else $error("main decrement misdecoded");   // [R9]

  property p_rsvd_pre;
    tx_coef_word_out[1:0] == 2'h3
      |-> req_rsvd_out[0] && !req_inc_out[0] && !req_dec_out[0] && !req_hold_out[0];
  endproperty
  a_rsvd_pre: assert property (p_rsvd_pre) else $error("reserved request taken as valid");   // [R10]

  property p_inc_post;
    tx_coef_word_out[5:4] == KCO_REQ_INC
      |-> req_inc_out[2] && !req_rsvd_out[2];
  endproperty
  a_inc_post: assert property (p_inc_post) else $error("post increment misdecoded");   // [R14]

  c_load2: cover property (lane2_coef_load_out);
  c_new_word: cover property (tx_word_new_out);
  c_status_rd: cover property (rd_fire && kco_addr_hit(rd_addr, KCO_IDX_STATUS));
  c_blocked: cover property (strobe_wr && wr_data[KCO_BIT_APPLY2] && !st_r.loc_ovr);

endmodule : kco_coef_override_ctrl

/* inc/kco_pkg.sv */
// Purpose: shared constants and decoders for the coefficient override bank
// Assumes: AXI4-Lite, 32-bit data, register index times four is the byte address
// Notes:   request fields are 2 bits; 01 counts as increment
package kco_pkg;

  // ==========================================================================
  // register indices and bus widths
  localparam int         KCO_AW         = 12;
  localparam logic [7:0] KCO_IDX_CTRL   = 8'hD0;
  localparam logic [7:0] KCO_IDX_STROBE = 8'hD1;
  localparam logic [7:0] KCO_IDX_STATUS = 8'hD2;
  localparam logic [7:0] KCO_IDX_WORD   = 8'hD4;
  localparam logic [7:0] KCO_IDX_COEF2  = 8'hE5;
  localparam logic [7:0] KCO_IDX_COEF3  = 8'hE9;

  // ==========================================================================
  // field positions
  localparam int KCO_BIT_PART_OVR = 16;
  localparam int KCO_BIT_LOC_OVR  = 17;
  localparam int KCO_BIT_NEW_WORD = 4;
  localparam int KCO_BIT_APPLY2   = 10;
  localparam int KCO_BIT_APPLY3   = 11;
  localparam int KCO_STAT0_LSB    = 0;
  localparam int KCO_STAT1_LSB    = 8;
  localparam int KCO_STAT2_LSB    = 16;
  localparam int KCO_STAT3_LSB    = 24;
  localparam int KCO_COEF_LSB     = 16;

  // ==========================================================================
  // reset values and encodings
  localparam logic       KCO_OVR_RST   = 1'b0;
  localparam logic [7:0] KCO_COEF_RST  = 8'h00;
  localparam logic [5:0] KCO_WORD_RST  = 6'h00;
  localparam logic [1:0] KCO_REQ_HOLD  = 2'h0;
  localparam logic [1:0] KCO_REQ_INC   = 2'h1;
  localparam logic [1:0] KCO_REQ_DEC   = 2'h2;
  localparam logic [1:0] KCO_RESP_OK   = 2'h0;
  localparam logic [1:0] KCO_RESP_DEC  = 2'h3;

  // byte address matches a register index
  function automatic logic kco_addr_hit(input logic [KCO_AW-1:0] addr, input logic [7:0] idx);
    return addr[KCO_AW-1:2] == {2'h0, idx};
  endfunction : kco_addr_hit

  // byte-lane merge of a write into an old image
  function automatic logic [31:0] kco_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = wd[8*i +: 8];
    end
    return res;
  endfunction : kco_merge

  // one-hot {reserved, decrement, increment, hold}
  function automatic logic [3:0] kco_req_decode(input logic [1:0] req);
    logic [3:0] res;
    case (req)
      KCO_REQ_HOLD: res = 4'h1;
      KCO_REQ_INC:  res = 4'h2;
      KCO_REQ_DEC:  res = 4'h4;
      default:      res = 4'h8;
    endcase
    return res;
  endfunction : kco_req_decode

endpackage : kco_pkg

/* verilog/kco_req_decode.sv */
// Purpose: splits the coefficient update word into per-tap request flags
// Assumes: word bits 5:4 post, 3:2 main, 1:0 pre
// Notes:   index 2 is post-cursor, 1 main, 0 pre-cursor
`timescale 1ns/1ps
module kco_req_decode (
  // word
  input  wire logic [5:0] word_in,
  // flags
  output logic      [2:0] hold_out,
  output logic      [2:0] inc_out,
  output logic      [2:0] dec_out,
  output logic      [2:0] rsvd_out
);
  import kco_pkg::*;

  // ==========================================================================
  // per-field decode
  for (genvar g = 0; g < 3; g++) begin : g_fld
    assign {rsvd_out[g], dec_out[g], inc_out[g], hold_out[g]} = kco_req_decode(word_in[2*g +: 2]);
  end

endmodule : kco_req_decode

/* verilog/kco_axil_slave.sv */
// Purpose: AXI4-Lite slave front end, one write and one read in flight
// Assumes: register image answers combinationally to the held address
// Notes:   answer one edge after address and data are both held
`timescale 1ns/1ps
module kco_axil_slave (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // write channels
  input  wire logic [kco_pkg::KCO_AW-1:0] s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic      [1:0]                s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  // read channels
  input  wire logic [kco_pkg::KCO_AW-1:0] s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic      [31:0]               s_axi_rdata_out,
  output logic      [1:0]                s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  // register side
  output logic                           wr_fire_out,
  output logic      [kco_pkg::KCO_AW-1:0] wr_addr_out,
  output logic      [31:0]               wr_data_out,
  output logic      [3:0]                wr_strb_out,
  input  wire logic                      wr_hit_in,
  output logic                           rd_fire_out,
  output logic      [kco_pkg::KCO_AW-1:0] rd_addr_out,
  input  wire logic [31:0]               rd_data_in,
  input  wire logic                      rd_hit_in
);
  import kco_pkg::*;

  typedef struct packed {
    logic              aw_v;
    logic [KCO_AW-1:0] aw_a;
    logic              w_v;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              b_v;
    logic [1:0]        b_r;
    logic              ar_v;
    logic [KCO_AW-1:0] ar_a;
    logic              r_v;
    logic [1:0]        r_r;
    logic [31:0]       r_d;
  } kco_axi_t;

  kco_axi_t st_r;
  kco_axi_t st_nxt;

  // ==========================================================================
  // handshakes
  assign s_axi_awready_out = !st_r.aw_v;
  assign s_axi_wready_out  = !st_r.w_v;
  assign s_axi_arready_out = !st_r.ar_v;
  assign wr_fire_out       = st_r.aw_v & st_r.w_v & ~st_r.b_v;
  assign rd_fire_out       = st_r.ar_v & ~st_r.r_v;
  assign wr_addr_out       = st_r.aw_a;
  assign wr_data_out       = st_r.w_d;
  assign wr_strb_out       = st_r.w_s;
  assign rd_addr_out       = st_r.ar_a;
  assign s_axi_bvalid_out  = st_r.b_v;
  assign s_axi_bresp_out   = st_r.b_r;
  assign s_axi_rvalid_out  = st_r.r_v;
  assign s_axi_rresp_out   = st_r.r_r;
  assign s_axi_rdata_out   = st_r.r_d;

  always_comb begin
    st_nxt = st_r;
    if (s_axi_awvalid_in && !st_r.aw_v) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_a = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_r.w_v) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_d = s_axi_wdata_in;
      st_nxt.w_s = s_axi_wstrb_in;
    end
    if (st_r.b_v && s_axi_bready_in) st_nxt.b_v = 1'b0;
    if (wr_fire_out) begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v  = 1'b0;
      st_nxt.b_v  = 1'b1;
      st_nxt.b_r  = wr_hit_in ? KCO_RESP_OK : KCO_RESP_DEC;
    end
    if (s_axi_arvalid_in && !st_r.ar_v) begin
      st_nxt.ar_v = 1'b1;
      st_nxt.ar_a = s_axi_araddr_in;
    end
    if (st_r.r_v && s_axi_rready_in) st_nxt.r_v = 1'b0;
    if (rd_fire_out) begin
      st_nxt.ar_v = 1'b0;
      st_nxt.r_v  = 1'b1;
      st_nxt.r_r  = rd_hit_in ? KCO_RESP_OK : KCO_RESP_DEC;
      st_nxt.r_d  = rd_hit_in ? rd_data_in : 32'h0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) st_r <= '0;
    else            st_r <= st_nxt;
  end

endmodule : kco_axil_slave

/* bench/kco_partner.sv */
// Purpose: training-side model feeding status and counting pulses
// Assumes: one clock shared with the bank
// Notes:   lane n status is pattern xor n
`timescale 1ns/1ps
module kco_partner (
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            sys_rst_in,
  // training side
  input  wire logic [5:0]      pat_in,
  output logic      [3:0][5:0] stat_out,
  output logic      [5:0]      lt_out,
  // from the bank
  input  wire logic            ld2_in,
  input  wire logic            ld3_in,
  input  wire logic            nw_in,
  input  wire logic [7:0]      c2_in,
  input  wire logic [7:0]      c3_in,
  output logic      [2:0][7:0] cnt_out,
  output logic      [15:0]     taps_out
);
  // ==========================================================================
  // pulse counters double as one-cycle width checks
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stat_out <= '0;
      lt_out   <= 6'h00;
      cnt_out  <= '0;
      taps_out <= 16'h0000;
    end else begin
      stat_out <= {pat_in ^ 6'h03, pat_in ^ 6'h02, pat_in ^ 6'h01, pat_in};
      lt_out   <= pat_in ^ 6'h15;
      cnt_out  <= cnt_out + {7'h00, nw_in, 7'h00, ld3_in, 7'h00, ld2_in};
      if (ld2_in) taps_out[7:0] <= c2_in;
      if (ld3_in) taps_out[15:8] <= c3_in;
    end
  end
endmodule : kco_partner

/* bench/tb_kco_coef_override_ctrl.sv */
// Purpose: self-checking bench for the coefficient override bank
// Assumes: byte address is four times the index
// Notes:   bready and rready stay high
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t bad %h %h", $time, a, e); end end
module tb_kco_coef_override_ctrl;
  import kco_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wrd, arr, bv, rv, ld2, ld3, nw, lovr, povr;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wdt = 32'h0, rdt;
  logic [1:0] bre, rre;
  logic [5:0] pat = 6'h00, lt, txw;
  logic [3:0][5:0] st;
  logic [7:0] c2, c3;
  logic [2:0] hl, ic, dc, rs;
  logic [2:0][7:0] cnt;
  logic [15:0] taps;
  int error_cnt = 0, check_count = 0;
  always #10 clk_in = ~clk_in;
  kco_coef_override_ctrl i_kco_coef_override_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdt),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(bre),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdt), .s_axi_rresp_out(rre), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(1'b1), .lane0_status_in(st[0]), .lane1_status_in(st[1]), .lane2_status_in(st[2]),
    .lane3_status_in(st[3]), .lt_coef_word_in(lt), .lane2_coef_load_out(ld2), .lane2_coef_out(c2),
    .lane3_coef_load_out(ld3), .lane3_coef_out(c3), .local_rx_override_out(lovr),
    .partner_coef_override_en_out(povr), .tx_coef_word_out(txw), .tx_word_new_out(nw),
    .req_hold_out(hl), .req_inc_out(ic), .req_dec_out(dc), .req_rsvd_out(rs));
  kco_partner i_kco_partner (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pat_in(pat), .stat_out(st),
    .lt_out(lt), .ld2_in(ld2), .ld3_in(ld3), .nw_in(nw), .c2_in(c2), .c3_in(c3), .cnt_out(cnt), .taps_out(taps));
  // ==========================================================================
  // bus tasks
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = 2'h0);
    awa <= {2'h0, idx, 2'h0};
    wdt <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv);
    `CHK(bre, er)
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er = 2'h0);
    ara <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    `CHK(rdt, e)
    `CHK(rre, er)
  endtask : rd
  task automatic sett;
    repeat (2) @(posedge clk_in);
  endtask : sett
  // ==========================================================================
  // scenarios
  task automatic t_status;
    pat <= 6'h2C;
    sett();
    rd(KCO_IDX_STATUS, 32'h2F2E2D2C);
    wr(KCO_IDX_STATUS, 32'hFFFFFFFF);
    rd(KCO_IDX_STATUS, 32'h2F2E2D2C);
    rd(8'hD3, 32'h0, 2'h3);
    `CHK(taps, 16'h0000)
    $display("status test done");
  endtask : t_status
  task automatic t_apply;
    wr(KCO_IDX_COEF2, 32'h00AB0000);
    wr(KCO_IDX_COEF3, 32'h00CD0000);
    wr(KCO_IDX_STROBE, 32'h00000C00);
    sett();
    `CHK(cnt[1:0], 16'h0000)
    wr(KCO_IDX_CTRL, 32'h00020000);
    `CHK(lovr, 1'b1)
    wr(KCO_IDX_STROBE, 32'h00000400);
    wr(KCO_IDX_STROBE, 32'h00000800);
    wr(KCO_IDX_STROBE, 32'h0);
    sett();
    `CHK(cnt[1:0], 16'h0101)
    `CHK(taps, 16'hCDAB)
    rd(KCO_IDX_STROBE, 32'h0);
    $display("apply test done");
  endtask : t_apply
  task automatic t_word;
    rd(KCO_IDX_WORD, 32'h39);
    wr(KCO_IDX_WORD, 32'h24);
    rd(KCO_IDX_WORD, 32'h39);
    wr(KCO_IDX_CTRL, 32'h00030000);
    `CHK(povr, 1'b1)
    wr(KCO_IDX_WORD, 32'h24);
    rd(KCO_IDX_WORD, 32'h24);
    `CHK(txw, 6'h24)
    `CHK({dc, ic, hl, rs}, 12'h888)
    wr(KCO_IDX_STROBE, 32'h10);
    sett();
    `CHK(cnt[2], 8'h01)
    wr(KCO_IDX_WORD, 32'h3F);
    sett();
    `CHK(rs, 3'h7)
    wr(KCO_IDX_STROBE, 32'h10);
    sett();
    `CHK(cnt[2], 8'h01)
    $display("word test done");
  endtask : t_word
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    rd(KCO_IDX_CTRL, 32'h0);
    t_status();
    t_apply();
    t_word();
    give_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_kco_coef_override_ctrl
